/* File: bench/mil_core_seq.sv */
// core sequencer model: quarter phases and instruction ends
`timescale 1ns/1ps
`default_nettype none
module mil_core_seq
   import mil_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   output logic [1:0] q_phase,
   output logic insn_end
);
   // free-running quarter count, one instruction per four clocks
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) q_phase <= MIL_PHASE_RST;
      else q_phase <= q_phase + 2'h1;
   end
   assign insn_end = (q_phase == MIL_PHASE_Q4); // last quarter closes the cycle
endmodule
`default_nettype wire

/* File: bench/mil_irq_assertions.sv */
// port checker for the interrupt logic
`timescale 1ns/1ps
`default_nettype none
module mil_irq_assertions
   import mil_pkg::*;
#(
   parameter int PORT_W = MIL_PORT_WIDTH
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] q_phase,
   input wire logic ext_irq_pin,
   input wire logic ext_edge_select,
   input wire logic [7:0] tick_counter,
   input wire logic tick_inc,
   input wire logic return_from_irq,
   input wire logic [PORT_W-1:0] analog_select_reg,
   input wire logic [7:0] irq_control_reg,
   input wire logic [PORT_W-1:0] port_read,
   input wire logic vector_load,
   input wire logic [12:0] vector_addr,
   input wire logic stack_push
);
   // ----------
   // properties
   // ----------
   logic glob_en;
   assign glob_en = irq_control_reg[MIL_BIT_GLOBAL_EN];
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // four quiet cycles cover the one-cycle image lag
   sequence gie_low_s; !glob_en [*4]; endsequence
   sequence ext_edge_s;
      $rose(ext_irq_pin) && ext_edge_select && !analog_select_reg[2] && q_phase == MIL_PHASE_Q4;
   endsequence
   reset_gie_a: assert property ($fell(rst) |-> !glob_en)
      else $error("global enable set after reset");
   gie_blocks_a: assert property (gie_low_s |=> !vector_load)
      else $error("vector taken with global enable clear");
   vector_addr_a: assert property (vector_load |-> vector_addr == MIL_VECTOR_ADDR && stack_push)
      else $error("vector address or push wrong");
   // the image lags one clock, so the cleared enable shows a clock after the pulse
   take_clears_a: assert property (vector_load |-> ##1 (!glob_en && !vector_load))
      else $error("global enable kept on vector");
   return_sets_a: assert property (return_from_irq |-> ##[1:2] glob_en)
      else $error("return did not set global enable");
   ext_flag_a: assert property (ext_edge_s |-> ##[1:3] irq_control_reg[MIL_BIT_EXTF])
      else $error("edge did not set pin flag");
   tick_flag_a: assert property (tick_inc && tick_counter == MIL_TICK_MAX |-> ##[1:2] irq_control_reg[MIL_BIT_TOF])
      else $error("rollover did not set tick flag");
   analog_zero_a: assert property ((port_read & $past(analog_select_reg)) == '0)
      else $error("analog pin read nonzero");
endmodule
`default_nettype wire
bind mil_irq_logic mil_irq_assertions #(.PORT_W(PORT_W)) chk (.mclk, .rst, .q_phase, .ext_irq_pin,
   .ext_edge_select, .tick_counter, .tick_inc, .return_from_irq, .analog_select_reg, .irq_control_reg,
   .port_read, .vector_load, .vector_addr, .stack_push);

/* File: bench/test_mcu_interrupt_logic.sv */
// self-checking bench for the interrupt logic
`timescale 1ns/1ps
`default_nettype none
module test_mcu_interrupt_logic;
   import mil_pkg::*;
   logic mclk = 0, rst = 1, insn_end, ctrl_wr = 0, req_a_wr = 0, req_b_wr = 0, en_a_wr = 0, en_b_wr = 0;
   logic gie_clear_insn = 0, return_from_irq = 0, sleep_enter = 0, port_insn = 0, ext_irq_pin = 0;
   logic ext_edge_select = 1, tick_inc = 0, core_irq_req, vector_load, stack_push, wake_up, sleeping;
   logic [1:0] q_phase;
   logic [7:0] ctrl_wdata = 0, req_a_wdata = 0, req_b_wdata = 0, en_a_wdata = 0, en_b_wdata = 0;
   logic [7:0] periph_evt_a = 0, periph_evt_b = 0, tick_counter = 0, general_port = 0;
   logic [7:0] pin_change_mask_reg = 0, analog_select_reg = 0, irq_control_reg, port_read;
   logic [7:0] periph_request_reg_a, periph_request_reg_b, periph_enable_reg_a, periph_enable_reg_b;
   logic [12:0] next_pc = 13'h0123, vector_addr, stack_push_addr;
   int mismatches = 0, total_checks = 0, lat;
   always #25 mclk = ~mclk;
   mil_core_seq seq (.mclk, .rst, .q_phase, .insn_end);
   mil_irq_logic uut (.mclk, .rst, .q_phase, .insn_end, .ctrl_wr, .ctrl_wdata, .req_a_wr, .req_a_wdata,
      .req_b_wr, .req_b_wdata, .en_a_wr, .en_a_wdata, .en_b_wr, .en_b_wdata, .periph_evt_a, .periph_evt_b,
      .gie_clear_insn, .return_from_irq, .sleep_enter, .port_insn, .next_pc, .ext_irq_pin, .ext_edge_select,
      .tick_counter, .tick_inc, .general_port, .pin_change_mask_reg, .analog_select_reg, .irq_control_reg,
      .periph_request_reg_a, .periph_request_reg_b, .periph_enable_reg_a, .periph_enable_reg_b, .port_read,
      .core_irq_req, .vector_load, .vector_addr, .stack_push, .stack_push_addr, .wake_up, .sleeping);
   // ----------
   // helpers
   // ----------
   task step(input int n);
      repeat (n) @(posedge mclk);
      #5;
   endtask
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr_ctrl(input logic [7:0] v);
      ctrl_wr = 1; ctrl_wdata = v; step(1); ctrl_wr = 0; step(1);
   endtask
   task pulse_ret;
      return_from_irq = 1; step(1); return_from_irq = 0;
   endtask
   // counts instruction ends until the vector, bounded
   task wait_vec;
      lat = 0;
      for (int i = 0; i < 200 && vector_load !== 1'b1; i++) begin
         if (insn_end === 1'b1) lat++;
         step(1);
      end
   endtask
   task quiet(input int n);
      for (int i = 0; i < n; i++) begin
         chk("no vector", vector_load, 1'b0);
         step(1);
      end
   endtask
   // ----------
   // scenarios
   // ----------
   task t_ext;
      wr_ctrl(8'h90);
      while (q_phase !== MIL_PHASE_Q4) step(1);
      ext_irq_pin = 1; // rising edge in the last quarter
      step(1);
      wait_vec;
      chk("vector addr", vector_addr, MIL_VECTOR_ADDR);
      chk("push addr", stack_push_addr, next_pc);
      chk("push pulse", stack_push, 1'b1);
      chk("latency ok", lat inside {[MIL_LATENCY_MIN:MIL_LATENCY_MAX]}, 1'b1);
      step(2);
      chk("ctrl after take", irq_control_reg, 8'h12);
      wr_ctrl(8'h10); // service clears the pin flag first
      pulse_ret;
      step(2);
      chk("gie back", irq_control_reg, 8'h90);
      quiet(20);
      wr_ctrl(8'h00);
      ext_edge_select = 0;
      ext_irq_pin = 0;
      step(4);
      chk("falling flag", irq_control_reg, 8'h02);
      wr_ctrl(8'h00);
      $display("ext pin test done");
   endtask
   task t_tick;
      wr_ctrl(8'h20);
      tick_counter = MIL_TICK_MAX; tick_inc = 1; step(1); tick_inc = 0; tick_counter = 8'h00;
      step(2);
      chk("tick flag", irq_control_reg, 8'h24);
      quiet(12);
      pulse_ret;
      step(1);
      chk("core request", core_irq_req, 1'b1);
      wait_vec;
      chk("pending taken", vector_load, 1'b1);
      wr_ctrl(8'h00);
      $display("tick test done");
   endtask
   task t_periph;
      en_a_wr = 1; en_a_wdata = 8'h01; step(1); en_a_wr = 0;
      wr_ctrl(8'h80);
      periph_evt_a = 8'h01; step(1); periph_evt_a = 8'h00;
      step(2);
      chk("periph flag", periph_request_reg_a, 8'h01);
      quiet(12);
      wr_ctrl(8'hC0);
      gie_clear_insn = 1; step(1); gie_clear_insn = 0;
      quiet(8);
      chk("kept pending", periph_request_reg_a, 8'h01);
      pulse_ret;
      wait_vec;
      chk("periph taken", vector_load, 1'b1);
      req_a_wr = 1; req_a_wdata = 8'h00; step(1); req_a_wr = 0;
      wr_ctrl(8'h00);
      $display("peripheral test done");
   endtask
   task t_port;
      pin_change_mask_reg = 8'h01; analog_select_reg = 8'h02;
      step(2);
      general_port = 8'h03;
      step(3);
      chk("change flag", irq_control_reg, 8'h01);
      chk("analog read", port_read, 8'h01);
      $display("port test done");
   endtask
   task t_sleep;
      wr_ctrl(8'h20);
      sleep_enter = 1; step(1); sleep_enter = 0; step(1);
      chk("asleep", sleeping, 1'b1);
      chk("no wake yet", wake_up, 1'b0);
      tick_counter = MIL_TICK_MAX; tick_inc = 1; step(1); tick_inc = 0; tick_counter = 8'h00;
      step(1);
      chk("wake pulse", wake_up, 1'b1);
      chk("no request", core_irq_req, 1'b0);
      step(1);
      chk("awake", sleeping, 1'b0);
      wr_ctrl(8'h00);
      $display("sleep test done");
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #500000;
      mismatches++;
      close_out;
   end
   initial begin
      repeat (20) @(posedge mclk);
      #5 rst = 0;
      step(1);
      chk("ctrl reset", irq_control_reg, MIL_CTRL_RESET);
      t_ext;
      t_tick;
      t_periph;
      t_port;
      t_sleep;
      close_out;
   end
endmodule
`default_nettype wire

/* File: rtl/mil_irq_logic.sv */
// interrupt collection, qualification and vectoring for the 8-bit core
// Operation
// - sources: ext pin, pin change, tick, timers, converter, serial, faults, captures
// - global enable set allows unmasked requests; clear blocks all
// - any reset forces the global enable to zero
// - taking a request clears global enable, pushes return, vectors to 0004h
// - return-from-irq sets global enable again
// - control register holds ext, pin-change, tick flags; peripherals in two registers
// - ext and pin-change latency is three or four instruction cycles
// - request blocked by a global-enable clear stays pending until re-enabled
// - ext pin edge-triggered; edge-select one rising, zero falling
// - valid ext edge sets ext flag during Q4-Q1 phases
// - clearing ext enable stops ext flag requesting
// - ext interrupt wakes from sleep if enabled before sleep
// - analog-selected pins read zero and never interrupt
// - tick counter rollover FFh to 00h sets tick flag; tick enable gates
// - masked port pin change sets pin-change flag; pin-change enable gates
// - pin change during a port instruction may be lost
// - flags set regardless of their enable or global enable
`timescale 1ns/1ps
`default_nettype none
module mil_irq_logic
   import mil_pkg::*;
#(
   parameter int PORT_W = MIL_PORT_WIDTH,
   parameter int PER_W = MIL_PERIPH_WIDTH
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [1:0] q_phase,
   input wire logic insn_end,
   input wire logic ctrl_wr,
   input wire logic [7:0] ctrl_wdata,
   input wire logic req_a_wr,
   input wire logic [PER_W-1:0] req_a_wdata,
   input wire logic req_b_wr,
   input wire logic [PER_W-1:0] req_b_wdata,
   input wire logic en_a_wr,
   input wire logic [PER_W-1:0] en_a_wdata,
   input wire logic en_b_wr,
   input wire logic [PER_W-1:0] en_b_wdata,
   input wire logic [PER_W-1:0] periph_evt_a,
   input wire logic [PER_W-1:0] periph_evt_b,
   input wire logic gie_clear_insn,
   input wire logic return_from_irq,
   input wire logic sleep_enter,
   input wire logic port_insn,
   input wire logic [12:0] next_pc,
   input wire logic ext_irq_pin,
   input wire logic ext_edge_select,
   input wire logic [7:0] tick_counter,
   input wire logic tick_inc,
   input wire logic [PORT_W-1:0] general_port,
   input wire logic [PORT_W-1:0] pin_change_mask_reg,
   input wire logic [PORT_W-1:0] analog_select_reg,
   output logic [7:0] irq_control_reg,
   output logic [PER_W-1:0] periph_request_reg_a,
   output logic [PER_W-1:0] periph_request_reg_b,
   output logic [PER_W-1:0] periph_enable_reg_a,
   output logic [PER_W-1:0] periph_enable_reg_b,
   output logic [PORT_W-1:0] port_read,
   output logic core_irq_req,
   output logic vector_load,
   output logic [12:0] vector_addr,
   output logic stack_push,
   output logic [12:0] stack_push_addr,
   output logic wake_up,
   output logic sleeping
);
   // ---------------------------------------------------------------
   // parameter checks
   // ---------------------------------------------------------------
   initial begin
      if (PORT_W < 1 || PORT_W > 16) $error("port width out of range");
      if (PER_W < 1 || PER_W > 8) $error("peripheral register width out of range");
   end

   // ---------------------------------------------------------------
   // flag storage
   // ---------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic [PER_W-1:0] req_a_r, req_b_r, en_a_r, en_b_r;
   logic ext_pin_d_r;
   logic [PORT_W-1:0] port_d_r;
   mil_state_t state_r;
   logic [1:0] lat_cnt_r;

   // digital view of the port; analog pins read zero
   logic [PORT_W-1:0] port_dig;
   assign port_dig = general_port & ~analog_select_reg;

   // the ext pin doubles as port bit 2, so it shares that bit's analog select;
   // an analog pin can therefore never raise the ext flag, whatever its level
   logic ext_dig;
   assign ext_dig = ext_irq_pin & ~analog_select_reg[2 % PORT_W];

   // ext edge detection sampled only in the Q4-Q1 window; pin change every clock outside a port instruction, tick rollover every clock
   logic ext_window, ext_edge, pc_change, tick_roll;
   assign ext_window = (q_phase == MIL_PHASE_Q4) || (q_phase == MIL_PHASE_RST);
   assign ext_edge = ext_window && (ext_edge_select ? (ext_dig && !ext_pin_d_r)
                                                    : (!ext_dig && ext_pin_d_r));
   // a change during a port instruction is flagged once it ends; one that reverts is lost
   assign pc_change = |((port_dig ^ port_d_r) & pin_change_mask_reg) && !port_insn;
   assign tick_roll = tick_inc && (tick_counter == MIL_TICK_MAX);

   // previous samples for edge and change detection
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ext_pin_d_r <= 1'b0;
         port_d_r <= '0;
      end else begin
         if (ext_window) begin
            ext_pin_d_r <= ext_dig;
         end
         if (!port_insn) begin
            port_d_r <= port_dig;
         end
      end
   end

   // ---------------------------------------------------------------
   // control register: writes, hardware sets, global enable
   // ---------------------------------------------------------------
   logic take;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_r <= MIL_CTRL_RESET;
      end else begin
         if (ctrl_wr) begin
            ctrl_r <= ctrl_wdata; // software clears flags by writing zero
         end
         // global enable: clearing instruction and vectoring both drop it,
         // a return raises it again; the return is placed last of the three
         // so that a return in the same cycle as a take leaves it set
         if (gie_clear_insn) begin
            ctrl_r[MIL_BIT_GLOBAL_EN] <= 1'b0;
         end
         if (take) begin
            ctrl_r[MIL_BIT_GLOBAL_EN] <= 1'b0;
         end
         if (return_from_irq) begin
            ctrl_r[MIL_BIT_GLOBAL_EN] <= 1'b1;
         end
         // hardware sets last so they win over a same-cycle write
         if (ext_edge) begin
            ctrl_r[MIL_BIT_EXTF] <= 1'b1;
         end
         if (pc_change) begin
            ctrl_r[MIL_BIT_PCF] <= 1'b1;
         end
         if (tick_roll) begin
            ctrl_r[MIL_BIT_TOF] <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // peripheral request and enable registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_a_r <= MIL_PERIPH_RESET[PER_W-1:0];
         req_b_r <= MIL_PERIPH_RESET[PER_W-1:0];
      end else begin
         // set wins over a software clear
         req_a_r <= (req_a_wr ? req_a_wdata : req_a_r) | periph_evt_a;
         req_b_r <= (req_b_wr ? req_b_wdata : req_b_r) | periph_evt_b;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         en_a_r <= MIL_PERIPH_RESET[PER_W-1:0];
         en_b_r <= MIL_PERIPH_RESET[PER_W-1:0];
      end else begin
         if (en_a_wr) begin
            en_a_r <= en_a_wdata;
         end
         if (en_b_wr) begin
            en_b_r <= en_b_wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // request qualification
   // ---------------------------------------------------------------
   // each source is an enable/flag pair; the flag is stored whatever the
   // enable holds, so a late enable picks up an event that came earlier.
   // software must therefore clear stale flags before enabling a source.
   logic ctrl_pend, per_pend, any_pend, gie_now;

   // control-register sources: tick rollover, ext pin, pin change
   assign ctrl_pend = (ctrl_r[MIL_BIT_TICK_EN] && ctrl_r[MIL_BIT_TOF])
                    || (ctrl_r[MIL_BIT_EXTE] && ctrl_r[MIL_BIT_EXTF])
                    || (ctrl_r[MIL_BIT_PCE] && ctrl_r[MIL_BIT_PCF]);

   // peripheral sources pass only through the peripheral gate
   assign per_pend = ctrl_r[MIL_BIT_PERIPH_GATE] && |((req_a_r & en_a_r) | (req_b_r & en_b_r));

   // pending regardless of the global enable; sleep wake uses this alone
   assign any_pend = ctrl_pend || per_pend;

   // a clearing instruction masks requests due now; flags stay pending
   // and are taken once the global enable comes back
   assign gie_now = ctrl_r[MIL_BIT_GLOBAL_EN] && !gie_clear_insn;
   // take only after latency count so vectoring lands 3-4 cycles after the event
   assign take = (state_r == MIL_WAIT_VEC) && insn_end && gie_now && any_pend
                 && (lat_cnt_r == 2'(MIL_LATENCY_MIN - 1));

   // ---------------------------------------------------------------
   // sequencer: run, sleep, wait for vector
   // ---------------------------------------------------------------
   // run: watch for a qualified request or a sleep command
   // sleep: core halted; any enabled pending flag resumes it
   // wait: count instruction ends so the vector lands three
   //       instruction cycles after the flag; dropping the request
   //       or the global enable returns to run with flags intact
   // the count restarts on every entry, so a withdrawn request that
   // comes back later sees the full latency again
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_r <= MIL_RUN;
         lat_cnt_r <= 2'h0;
      end else begin
         unique case (state_r)
            MIL_RUN: begin
               lat_cnt_r <= 2'h0;
               if (sleep_enter) begin
                  state_r <= MIL_SLEEP;
               end else if (gie_now && any_pend) begin
                  state_r <= MIL_WAIT_VEC;
               end
            end
            MIL_SLEEP: begin
               // any enabled pending source wakes, ext pin only if enabled
               if (any_pend) begin
                  state_r <= MIL_RUN;
               end
            end
            MIL_WAIT_VEC: begin
               if (!gie_now || !any_pend) begin
                  state_r <= MIL_RUN; // request withdrawn, flags kept
               end else if (take) begin
                  state_r <= MIL_RUN;
               end else if (insn_end && lat_cnt_r != 2'(MIL_LATENCY_MIN - 1)) begin
                  lat_cnt_r <= lat_cnt_r + 2'h1;
               end
            end
            default: state_r <= MIL_RUN;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   // every output is a flop, so the core sees each event one clock
   // after it happens here; vector and push pulse for one clock only,
   // while the two addresses hold until the next take
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         core_irq_req <= 1'b0;
         vector_load <= 1'b0;
         vector_addr <= 13'h0000;
         stack_push <= 1'b0;
         stack_push_addr <= 13'h0000;
         wake_up <= 1'b0;
         sleeping <= 1'b0;
         port_read <= '0;
      end else begin
         core_irq_req <= gie_now && any_pend;
         vector_load <= take;
         stack_push <= take;
         if (take) begin
            vector_addr <= MIL_VECTOR_ADDR;
            stack_push_addr <= next_pc;
         end
         wake_up <= (state_r == MIL_SLEEP) && any_pend;
         sleeping <= (state_r == MIL_SLEEP);
         port_read <= port_dig;
      end
   end


   // register images presented to the core's read path
   // limitation: a read in the cycle right after a write shows the old value
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_control_reg <= MIL_CTRL_RESET;
         periph_request_reg_a <= '0;
         periph_request_reg_b <= '0;
         periph_enable_reg_a <= '0;
         periph_enable_reg_b <= '0;
      end else begin
         irq_control_reg <= ctrl_r;
         periph_request_reg_a <= req_a_r;
         periph_request_reg_b <= req_b_r;
         periph_enable_reg_a <= en_a_r;
         periph_enable_reg_b <= en_b_r;
      end
   end
endmodule
`default_nettype wire

/* File: rtl/mil_pkg.sv */
// constants and types shared by the interrupt logic
package mil_pkg;
   localparam logic [12:0] MIL_VECTOR_ADDR = 13'h0004;   // service entry address
   localparam logic [7:0] MIL_TICK_MAX = 8'hFF;          // rollover point of the tick counter
   localparam int MIL_PORT_WIDTH = 8;
   localparam int MIL_PERIPH_WIDTH = 8;
   localparam logic [1:0] MIL_PHASE_Q4 = 2'h3;           // last quarter phase
   localparam logic [1:0] MIL_PHASE_RST = 2'h0;
   localparam int MIL_LATENCY_MIN = 3;                   // instruction cycles, event to vector
   localparam int MIL_LATENCY_MAX = 4;
   // control register bit positions
   localparam int MIL_BIT_GLOBAL_EN = 7;
   localparam int MIL_BIT_PERIPH_GATE = 6;
   localparam int MIL_BIT_TICK_EN = 5;
   localparam int MIL_BIT_EXTE = 4;
   localparam int MIL_BIT_PCE = 3;
   localparam int MIL_BIT_TOF = 2;
   localparam int MIL_BIT_EXTF = 1;
   localparam int MIL_BIT_PCF = 0;
   localparam logic [7:0] MIL_CTRL_RESET = 8'h00;
   localparam logic [7:0] MIL_PERIPH_RESET = 8'h00;
   typedef enum logic [1:0] {
      MIL_RUN,
      MIL_SLEEP,
      MIL_WAIT_VEC
   } mil_state_t;
endpackage
